// ===== verilog/fitc_top.sv
// Our own choices: the placing of the registers and the APB slave port.
module fitc_top #(
    parameter int APB_AW = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic store_valid,
    output logic [63:0] store_data,
    output logic [1:0] store_width,
    output logic exc_req,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // elaboration check

    if (APB_AW < 8 || APB_AW > 32) begin : g_bad_aw
        $error("fitc_top: APB_AW must lie between 8 and 32");
    end

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    localparam int FP_N_W = fitc_pkg::FP_N;

    fitc_pkg::fitc_state_s state_r;
    fitc_pkg::fitc_state_s state_nxt;

    logic setup;
    logic acc;
    logic hit;
    logic wr_acc;
    logic [7:0] off;
    logic [31:0] rd_val;
    logic busy;
    logic start;
    logic rup_upd;
    logic imask;
    logic [FP_N_W-1:0] fp_set;
    logic [FP_N_W-1:0] fp_clr;
    logic [fitc_pkg::IRQ_N-1:0] irq_set;
    logic [fitc_pkg::IRQ_N-1:0] irq_clr;
    fitc_pkg::fitc_rc_e rc;
    fitc_pkg::fitc_wid_e wid;
    logic [63:0] c_res;
    logic [63:0] c_indef;
    logic c_ovf;
    logic c_inx;
    logic c_inc;

    ////////////////////////////////////////////////////////////////////////////
    // apb decode: zero wait states, every access ends in its first access cycle

    assign setup = psel & ~penable;
    assign acc = psel & penable;
    assign off = paddr[7:0];
    assign hit = ((paddr >> 8) == '0) && (off[1:0] == 2'h0) && (off <= fitc_pkg::A_LAST);
    assign wr_acc = acc & pwrite & hit;
    assign busy = (state_r.fsm == fitc_pkg::FITC_CONV);
    assign imask = state_r.ctrl[fitc_pkg::C_IMASK];
    assign rc = fitc_pkg::fitc_rc_e'(state_r.ctrl[fitc_pkg::C_RC +: 2]);
    assign wid = fitc_pkg::fitc_wid_e'(state_r.ctrl[fitc_pkg::C_WID +: 2]);

    assign pready = acc;
    assign pslverr = acc & ~hit;
    assign prdata = state_r.rdata;

    ////////////////////////////////////////////////////////////////////////////
    // converter datapath

    fitc_conv u_conv (
        .sign(state_r.sexp[fitc_pkg::E_SIGN]),
        .exp_b(state_r.sexp[14:0]),
        .sig(state_r.sig),
        .rc(rc),
        .wid(wid),
        .result(c_res),
        .indef(c_indef),
        .overflow(c_ovf),
        .inexact(c_inx),
        .rnd_up(c_inc)
    );

    ////////////////////////////////////////////////////////////////////////////
    // read mux, sampled in the setup cycle so prdata comes from a flop

    always_comb begin
        rd_val = 32'h0;
        case (off)
            fitc_pkg::A_SIG_LO: rd_val = state_r.sig[31:0];
            fitc_pkg::A_SIG_HI: rd_val = state_r.sig[63:32];
            fitc_pkg::A_SEXP: rd_val[15:0] = state_r.sexp;
            fitc_pkg::A_CTRL: rd_val[4:0] = state_r.ctrl;
            fitc_pkg::A_RES_LO: rd_val = state_r.res[31:0];
            fitc_pkg::A_RES_HI: rd_val = state_r.res[63:32];
            fitc_pkg::A_FPST: begin
                rd_val[fitc_pkg::S_INV] = state_r.inv_flag;
                rd_val[fitc_pkg::S_PREC] = state_r.prec_flag;
                rd_val[fitc_pkg::S_RUP] = state_r.rup_bit;
                rd_val[fitc_pkg::S_BUSY] = busy;
            end
            fitc_pkg::A_IRQST: rd_val[fitc_pkg::IRQ_N-1:0] = state_r.irq_st;
            fitc_pkg::A_IRQEN: rd_val[fitc_pkg::IRQ_N-1:0] = state_r.irq_en;
            default: rd_val = 32'h0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        state_nxt = state_r;
        state_nxt.st_v = 1'b0;
        state_nxt.exc = 1'b0;
        start = 1'b0;
        rup_upd = 1'b0;
        fp_set = '0;
        fp_clr = '0;
        irq_set = '0;
        irq_clr = '0;

        if (setup) begin
            state_nxt.rdata = (!pwrite && hit) ? rd_val : 32'h0;
        end

        // operand and control are frozen while a conversion is in flight
        if (wr_acc) begin
            case (off)
                fitc_pkg::A_SIG_LO: if (!busy) state_nxt.sig[31:0] = pwdata;
                fitc_pkg::A_SIG_HI: if (!busy) state_nxt.sig[63:32] = pwdata;
                fitc_pkg::A_SEXP: if (!busy) state_nxt.sexp = pwdata[15:0];
                fitc_pkg::A_CTRL: if (!busy) state_nxt.ctrl = pwdata[4:0];
                fitc_pkg::A_CMD: start = pwdata[0] & ~busy;
                fitc_pkg::A_FPCLR: fp_clr = pwdata[FP_N_W-1:0];
                fitc_pkg::A_IRQCLR: irq_clr = pwdata[fitc_pkg::IRQ_N-1:0];
                fitc_pkg::A_IRQEN: state_nxt.irq_en = pwdata[fitc_pkg::IRQ_N-1:0];
                default: ;
            endcase
        end

        case (state_r.fsm)
            fitc_pkg::FITC_IDLE: begin
                if (start) begin
                    state_nxt.fsm = fitc_pkg::FITC_CONV;
                end
            end
            fitc_pkg::FITC_CONV: begin
                state_nxt.fsm = fitc_pkg::FITC_IDLE;
                irq_set[fitc_pkg::I_DONE] = 1'b1;
                state_nxt.res_w = wid;
                if (c_ovf) begin
                    fp_set[fitc_pkg::S_INV] = 1'b1;
                    irq_set[fitc_pkg::I_OVF] = 1'b1;
                    if (imask) begin
                        state_nxt.res = c_indef;
                        state_nxt.st_v = 1'b1;
                    end else begin
                        // no store; operand registers are left untouched
                        state_nxt.exc = 1'b1;
                        irq_set[fitc_pkg::I_EXC] = 1'b1;
                    end
                end else begin
                    state_nxt.res = c_res;
                    state_nxt.st_v = 1'b1;
                    fp_set[fitc_pkg::S_PREC] = c_inx;
                    rup_upd = 1'b1;
                end
            end
            default: state_nxt.fsm = fitc_pkg::FITC_IDLE;
        endcase

        // a hardware set in the cycle of a software clear wins
        state_nxt.inv_flag = (state_r.inv_flag & ~fp_clr[fitc_pkg::S_INV])
            | fp_set[fitc_pkg::S_INV];
        state_nxt.prec_flag = (state_r.prec_flag & ~fp_clr[fitc_pkg::S_PREC])
            | fp_set[fitc_pkg::S_PREC];
        state_nxt.rup_bit = rup_upd ? c_inc
            : (state_r.rup_bit & ~fp_clr[fitc_pkg::S_RUP]);
        state_nxt.irq_st = (state_r.irq_st & ~irq_clr) | irq_set;
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= fitc_pkg::ST_RST;
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign store_valid = state_r.st_v;
    assign store_data = state_r.res;
    assign store_width = state_r.res_w;
    assign exc_req = state_r.exc;
    assign irq = |(state_r.irq_st & state_r.irq_en);

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic conv_ovf_m;
    logic conv_ovf_u;
    logic conv_ok;
    logic pe_clr_wr;

    assign conv_ovf_m = busy & c_ovf & imask;
    assign conv_ovf_u = busy & c_ovf & ~imask;
    assign conv_ok = busy & ~c_ovf;
    assign pe_clr_wr = wr_acc & (off == fitc_pkg::A_FPCLR) & pwdata[fitc_pkg::S_PREC];

    chk_start_to_end: assert property (
        (wr_acc && off == fitc_pkg::A_CMD && pwdata[0] && !busy)
        |=> busy ##1 (!busy && (store_valid ^ exc_req)))
        else $error("start did not end in one store or one exception");

    chk_masked_indef: assert property (
        conv_ovf_m |=> store_valid && !exc_req && state_r.inv_flag
        && store_data == $past(c_indef))
        else $error("masked overflow did not store the indefinite value");

    chk_unmasked_nostore: assert property (
        conv_ovf_u |=> !store_valid && exc_req && state_r.inv_flag
        && $stable(state_r.sig) && $stable(state_r.sexp))
        else $error("unmasked overflow stored or lost the operand");

    chk_overflow_flag: assert property (
        (busy && c_ovf) |=> state_r.inv_flag && state_r.irq_st[fitc_pkg::I_OVF])
        else $error("overflow did not raise the invalid flag");

    chk_big_not_zero: assert property (
        (busy && state_r.sexp[14:0] >= fitc_pkg::EXP_BIG) |=> !(store_valid && store_data == 64'h0))
        else $error("huge operand stored zero");

    chk_up16_bound: assert property (
        (conv_ok && rc == fitc_pkg::RC_UP && wid == fitc_pkg::WID_16
        && !state_r.sexp[fitc_pkg::E_SIGN])
        |=> store_valid && store_data[15] == 1'b0)
        else $error("up mode 16-bit positive passed 32767");

    chk_prec_inexact: assert property (
        (conv_ok && c_inx) |=> state_r.prec_flag ##1 (state_r.prec_flag || $past(pe_clr_wr)))
        else $error("inexact conversion left precision flag clear");

    chk_up_frac: assert property (
        (conv_ok && c_inx && rc == fitc_pkg::RC_UP && !state_r.sexp[fitc_pkg::E_SIGN])
        |=> store_valid && store_data != 64'h0 && state_r.rup_bit)
        else $error("up mode positive fraction stored zero");

    chk_down_frac: assert property (
        (conv_ok && c_inx && rc == fitc_pkg::RC_DOWN && state_r.sexp[fitc_pkg::E_SIGN])
        |=> store_valid && store_data != 64'h0 && state_r.rup_bit)
        else $error("down mode negative fraction stored zero");

    chk_rup_tracks: assert property (
        conv_ok |=> state_r.rup_bit == $past(c_inc))
        else $error("round-up bit not refreshed by conversion");

    chk_prec_sticky: assert property (
        (state_r.prec_flag && !pe_clr_wr) |=> state_r.prec_flag)
        else $error("precision flag dropped without a clear");

    chk_rc_reset: assert property (
        disable iff (1'b0) $rose(presetn) |-> rc == fitc_pkg::RC_NEAR)
        else $error("rounding mode not nearest after reset");

    chk_neg_ovf: assert property (
        (busy && c_ovf && state_r.sexp[fitc_pkg::E_SIGN] && imask)
        |=> store_valid && store_data == $past(c_indef))
        else $error("negative overflow not handled as overflow");

    cov_masked_ovf: cover property (conv_ovf_m ##1 store_valid);
    cov_unmasked_ovf: cover property (conv_ovf_u ##1 exc_req);
    cov_up_frac: cover property (conv_ok && rc == fitc_pkg::RC_UP && c_inc);
    cov_irq: cover property ($rose(irq));

endmodule

// ===== verilog/fitc_pkg.sv
package fitc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register byte offsets, one aligned 32-bit word each
    localparam logic [7:0] A_SIG_LO = 8'h00;
    localparam logic [7:0] A_SIG_HI = 8'h04;
    localparam logic [7:0] A_SEXP = 8'h08;
    localparam logic [7:0] A_CTRL = 8'h0C;
    localparam logic [7:0] A_CMD = 8'h10;
    localparam logic [7:0] A_RES_LO = 8'h14;
    localparam logic [7:0] A_RES_HI = 8'h18;
    localparam logic [7:0] A_FPST = 8'h1C;
    localparam logic [7:0] A_FPCLR = 8'h20;
    localparam logic [7:0] A_IRQST = 8'h24;
    localparam logic [7:0] A_IRQCLR = 8'h28;
    localparam logic [7:0] A_IRQEN = 8'h2C;
    localparam logic [7:0] A_LAST = A_IRQEN;

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int E_SIGN = 15;
    localparam int C_RC = 0;
    localparam int C_WID = 2;
    localparam int C_IMASK = 4;
    localparam int S_INV = 0;
    localparam int S_PREC = 1;
    localparam int S_RUP = 2;
    localparam int S_BUSY = 3;
    localparam int FP_N = 3;
    localparam int I_DONE = 0;
    localparam int I_OVF = 1;
    localparam int I_EXC = 2;
    localparam int IRQ_N = 3;

    // reset: nearest rounding, 16-bit, invalid exception masked
    localparam logic [4:0] CTRL_RST = 5'h10;

    // biased exponents: value 0.5, 2^63 and 2^64
    localparam logic [14:0] EXP_HALF = 15'h3FFE;
    localparam logic [14:0] EXP_TOP = 15'h403E;
    localparam logic [14:0] EXP_BIG = 15'h403F;

    ////////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {RC_NEAR, RC_DOWN, RC_UP, RC_CHOP} fitc_rc_e;
    typedef enum logic [1:0] {WID_16, WID_32, WID_64, WID_RSV} fitc_wid_e;
    typedef enum logic {FITC_IDLE, FITC_CONV} fitc_fsm_e;

    typedef struct packed {
        fitc_fsm_e fsm;
        logic [63:0] sig;
        logic [15:0] sexp;
        logic [4:0] ctrl;
        logic inv_flag;
        logic prec_flag;
        logic rup_bit;
        logic [63:0] res;
        logic [1:0] res_w;
        logic st_v;
        logic exc;
        logic [IRQ_N-1:0] irq_st;
        logic [IRQ_N-1:0] irq_en;
        logic [31:0] rdata;
    } fitc_state_s;

    localparam fitc_state_s ST_RST = '{fsm: FITC_IDLE, ctrl: CTRL_RST, default: '0};

endpackage

// ===== verilog/fitc_conv.sv
module fitc_conv (
    input wire logic sign,
    input wire logic [14:0] exp_b,
    input wire logic [63:0] sig,
    input wire fitc_pkg::fitc_rc_e rc,
    input wire fitc_pkg::fitc_wid_e wid,
    output logic [63:0] result,
    output logic [63:0] indef,
    output logic overflow,
    output logic inexact,
    output logic rnd_up
);
    logic [5:0] sh;
    logic [127:0] wide;
    logic [63:0] ipart;
    logic rbit;
    logic sticky;
    logic inc;
    logic [64:0] mag;
    logic [64:0] base;
    logic [64:0] lim;
    logic [63:0] wmask;
    logic [63:0] sres;

    always_comb begin
        sh = 6'(fitc_pkg::EXP_TOP - exp_b);
        wide = {sig, 64'h0} >> sh;
        // below one half every bit is sticky; the shifter sees every |x| >= 1, those from 2^64 up being flagged as overflow
        if (exp_b < fitc_pkg::EXP_HALF) begin
            ipart = 64'h0;
            rbit = 1'b0;
            sticky = |sig;
        end else if (exp_b == fitc_pkg::EXP_HALF) begin
            ipart = 64'h0;
            rbit = sig[63];
            sticky = |sig[62:0];
        end else begin
            ipart = wide[127:64];
            rbit = wide[63];
            sticky = |wide[62:0];
        end
        inexact = rbit | sticky;
        case (rc)
            fitc_pkg::RC_NEAR: inc = rbit & (sticky | ipart[0]);
            fitc_pkg::RC_UP: inc = inexact & ~sign;
            fitc_pkg::RC_DOWN: inc = inexact & sign;
            default: inc = 1'b0;
        endcase
        mag = {1'b0, ipart} + {64'h0, inc};
        case (wid)
            fitc_pkg::WID_16: base = 65'h0_0000_0000_0000_8000;
            fitc_pkg::WID_32: base = 65'h0_0000_0000_8000_0000;
            default: base = 65'h0_8000_0000_0000_0000;
        endcase
        // negative side reaches one step further than the positive side
        lim = sign ? base : base - 65'h1;
        // overflow is judged on the rounded magnitude, so mode bounds follow
        overflow = (exp_b >= fitc_pkg::EXP_BIG) | (mag > lim);
        wmask = (base[63:0] << 1) - 64'h1;
        if (wid != fitc_pkg::WID_16 && wid != fitc_pkg::WID_32) begin
            wmask = 64'hFFFF_FFFF_FFFF_FFFF;
        end
        sres = sign ? 64'h0 - mag[63:0] : mag[63:0];
        result = sres & wmask;
        indef = base[63:0];
        rnd_up = inc & ~overflow;
    end

endmodule

// ===== bench/fitc_mem_model.sv
////////////////////////////////////////////////////////////////////////////////
// far side: the memory store path, with the numeric exception handler entry
module fitc_mem_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic store_valid,
    input wire logic [63:0] store_data,
    input wire logic [1:0] store_width,
    input wire logic exc_req,
    output logic got,
    output logic [66:0] got_note
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [63:0] mem_word;

    // a store and a handler request together is a fault; the request is reported
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            got <= 1'h0;
            got_note <= 67'h0;
            mem_word <= 64'h0;
        end else begin
            got <= store_valid | exc_req;
            if (store_valid) begin
                mem_word <= store_data;
            end
            got_note <= exc_req ? {1'h1, 66'h0} : {1'h0, store_width, store_data};
        end
    end
endmodule

// ===== bench/fitc_top_tb_top.sv
module fitc_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic pclk = 1'h0;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic store_valid;
    logic [63:0] store_data;
    logic [1:0] store_width;
    logic exc_req;
    logic irq;
    logic got;
    logic [66:0] got_note;
    int fail_count;
    int num_checks;
    logic [66:0] notes[$];
    logic [31:0] seed;
    logic [31:0] rd;
    logic err;
    logic [14:0] k;
    logic [63:0] sg;
    logic [15:0] e;
    logic [15:0] dd;

    localparam logic [66:0] EXC_NOTE = {1'h1, 66'h0};

    always #25 pclk = ~pclk;

    fitc_top u_fitc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .store_valid(store_valid), .store_data(store_data),
        .store_width(store_width), .exc_req(exc_req), .irq(irq));

    fitc_mem_model u_fitc_mem_model (.pclk(pclk), .presetn(presetn),
        .store_valid(store_valid), .store_data(store_data), .store_width(store_width),
        .exc_req(exc_req), .got(got), .got_note(got_note));

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [66:0] st(input logic [1:0] w, input logic [63:0] d);
        return {1'h0, w, d};
    endfunction

    task tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task cmp_note(input logic [66:0] ex, input logic [66:0] ac);
        num_checks++;
        if (ac !== ex) begin
            fail_count++;
            $display("mismatch at %0t: expected %h got %h", $time, ex, ac);
        end
    endtask

    task cmp_reg(input logic [31:0] ex, input logic [31:0] ac);
        num_checks++;
        if (ac !== ex) begin
            fail_count++;
            $display("mismatch at %0t: expected %h got %h", $time, ex, ac);
        end
    endtask

    // pready is sampled only at rising edges; request held until then
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (pready !== 1'h1) begin
            fail_count++;
            tally_and_finish;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task rchk(input logic [7:0] a, input logic [31:0] ex);
        apb(1'h0, a, 32'h0);
        cmp_reg(ex, rd);
    endtask

    // st3 is {round-up bit, precision flag, invalid flag} expected afterwards
    task run(input logic [15:0] sx, input logic [63:0] sig, input logic [4:0] c,
             input logic [66:0] note, input logic [2:0] st3, input logic clr);
        int n;
        apb(1'h1, fitc_pkg::A_SIG_LO, sig[31:0]);
        apb(1'h1, fitc_pkg::A_SIG_HI, sig[63:32]);
        apb(1'h1, fitc_pkg::A_SEXP, {16'h0, sx});
        apb(1'h1, fitc_pkg::A_CTRL, {27'h0, c});
        notes.push_back(note);
        apb(1'h1, fitc_pkg::A_CMD, 32'h1);
        n = 0;
        while (notes.size() != 0 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        if (n == 20) begin
            fail_count++;
            tally_and_finish;
        end
        rchk(fitc_pkg::A_FPST, {29'h0, st3});
        // operand high word must survive every conversion, trapped ones included
        rchk(fitc_pkg::A_SIG_HI, sig[63:32]);
        if (clr) begin
            apb(1'h1, fitc_pkg::A_FPCLR, 32'h7);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge pclk) begin
        if (got === 1'h1) begin
            if (notes.size() == 0) begin
                fail_count++;
                $display("mismatch at %0t: expected %h got %h", $time, 67'h0, got_note);
            end else begin
                cmp_note(notes.pop_front(), got_note);
            end
        end
    end

    initial begin
        repeat (100000) @(posedge pclk);
        fail_count++;
        tally_and_finish;
    end

    initial begin
        presetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        seed = 32'hF458;
        fail_count = 0;
        num_checks = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        rchk(fitc_pkg::A_CTRL, 32'h10);
        apb(1'h0, 8'h30, 32'h0);
        cmp_reg(32'h1, {31'h0, err});
        $display("test reset and map done");
        run(16'h400E, 64'hFFFF800000000000, 5'h10, st(0, 64'h8000), 3'h1, 1);
        run(16'h400E, 64'hFFFF800000000000, 5'h00, EXC_NOTE, 3'h1, 1);
        run(16'h401E, 64'hFFFFFFFF80000000, 5'h14, st(1, 64'h80000000), 3'h1, 1);
        run(16'h401D, 64'hFFFFFFFF00000000, 5'h16, st(1, 64'h80000000), 3'h1, 1);
        run(16'h400D, 64'hFFFE000000000000, 5'h12, st(0, 64'h7FFF), 3'h0, 1);
        run(16'h400D, 64'hFFFE800000000000, 5'h12, st(0, 64'h8000), 3'h1, 1);
        run(16'hC00E, 64'h8000800000000000, 5'h10, st(0, 64'h8000), 3'h2, 1);
        run(16'hC00E, 64'h8001000000000000, 5'h10, st(0, 64'h8000), 3'h1, 1);
        run(16'h3FFB, 64'h8000000000000000, 5'h12, st(0, 64'h1), 3'h6, 1);
        run(16'hBFFC, 64'hC000000000000000, 5'h11, st(0, 64'hFFFF), 3'h6, 1);
        run(16'hBFFC, 64'hC000000000000000, 5'h1B, st(2, 64'h0), 3'h2, 1);
        run(16'h3FFC, 64'h8000000000000000, 5'h14, st(1, 64'h0), 3'h2, 0);
        $display("test boundaries and fractions done");
        // exact integers in every mode; the earlier precision flag must stay up
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            k = seed[14:0] | 15'h1;
            sg = {k, 49'h0};
            e = 16'h400D;
            while (!sg[63]) begin
                sg = sg << 1;
                e = e - 16'h1;
            end
            e[15] = seed[15];
            dd = seed[15] ? 16'h0 - {1'h0, k} : {1'h0, k};
            run(e, sg, {3'h4, seed[17:16]}, st(0, {48'h0, dd}), 3'h2, 0);
        end
        apb(1'h1, fitc_pkg::A_FPCLR, 32'h7);
        rchk(fitc_pkg::A_FPST, 32'h0);
        $display("test random exact done");
        apb(1'h1, fitc_pkg::A_IRQCLR, 32'h7);
        apb(1'h1, fitc_pkg::A_IRQEN, 32'h0);
        run(16'h400D, 64'hFFFE000000000000, 5'h12, st(0, 64'h7FFF), 3'h0, 1);
        rchk(fitc_pkg::A_IRQST, 32'h1);
        cmp_reg(32'h0, {31'h0, irq});
        apb(1'h1, fitc_pkg::A_IRQEN, 32'h1);
        @(posedge pclk);
        #1;
        cmp_reg(32'h1, {31'h0, irq});
        apb(1'h1, fitc_pkg::A_IRQCLR, 32'h1);
        @(posedge pclk);
        #1;
        cmp_reg(32'h0, {31'h0, irq});
        rchk(fitc_pkg::A_IRQST, 32'h0);
        $display("test interrupt done");
        tally_and_finish;
    end
endmodule
